// >>> logic/lac_pkg.sv
// Constants shared by the lead angle controller
package lac_pkg;

  localparam int unsigned CLK_HZ  = 40_000_000;
  localparam int unsigned BAND_HZ = 100;
  localparam int unsigned HYST_HZ = 50;
  localparam int          NBAND   = 21;
  localparam int          SECT_SH = 5;

  localparam logic [4:0] TOP_BAND  = 5'h14;
  localparam logic [4:0] HALF_STEP = 5'h10;
  localparam logic [4:0] ROW_MAX   = 5'h07;
  localparam logic [4:0] FRAC_MAX  = 5'h1F;
  localparam logic [4:0] FB_MAX    = 5'h1F;

  localparam logic [1:0] MODE_EXT  = 2'h0;
  localparam logic [1:0] MODE_FREQ = 2'h1;
  localparam logic [1:0] MODE_PF   = 2'h2;

  localparam logic [7:0] TURN_UNITS = 8'hC0;
  localparam logic [7:0] HALF_TURN  = 8'h60;
  localparam logic signed [9:0] TURN_S  = 10'sh0C0;
  localparam logic signed [6:0] OFS_LIM = 7'sh0F;
  localparam logic signed [6:0] OFS_MIN = 7'sh71;

  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STAT   = 4'h4;
  localparam logic [3:0]  REG_ANGLE  = 4'h8;
  localparam logic [3:0]  REG_PERIOD = 4'hC;
  localparam int          CTRL_EN    = 0;
  localparam logic        CTRL_RST   = 1'b1;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  // Lead in 1.875 degree units, row = setting step, column = band
  localparam logic [4:0] FREQ_LUT [8][NBAND] = '{
    '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
      5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14},
    '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C,
      5'h0E, 5'h10, 5'h12, 5'h14, 5'h16, 5'h18, 5'h1A,
      5'h1C, 5'h1E, 5'h1E, 5'h1E, 5'h1E, 5'h1E, 5'h1E},
    '{5'h00, 5'h02, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0A,
      5'h0C, 5'h0E, 5'h10, 5'h11, 5'h13, 5'h15, 5'h17,
      5'h18, 5'h1A, 5'h1C, 5'h1E, 5'h1F, 5'h1F, 5'h1F},
    '{5'h00, 5'h01, 5'h03, 5'h04, 5'h06, 5'h07, 5'h09,
      5'h0A, 5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h12, 5'h13,
      5'h15, 5'h16, 5'h18, 5'h19, 5'h1B, 5'h1C, 5'h1E},
    '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h07,
      5'h08, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h10,
      5'h11, 5'h12, 5'h14, 5'h15, 5'h16, 5'h17, 5'h19},
    '{5'h00, 5'h01, 5'h01, 5'h02, 5'h03, 5'h04, 5'h04,
      5'h05, 5'h06, 5'h07, 5'h07, 5'h08, 5'h09, 5'h0A,
      5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0D, 5'h0E, 5'h0F},
    '{5'h00, 5'h01, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03,
      5'h04, 5'h04, 5'h05, 5'h05, 5'h06, 5'h06, 5'h07,
      5'h07, 5'h08, 5'h08, 5'h09, 5'h09, 5'h0A, 5'h0A},
    '{5'h00, 5'h01, 5'h01, 5'h01, 5'h01, 5'h02, 5'h02,
      5'h02, 5'h02, 5'h03, 5'h03, 5'h03, 5'h03, 5'h04,
      5'h04, 5'h04, 5'h04, 5'h05, 5'h05, 5'h05, 5'h05}
  };

endpackage : lac_pkg

// >>> logic/lac_lead_angle.sv
// Lead angle selection and commutation phase advance
`timescale 1ns/10ps
`default_nettype none
module lac_lead_angle
  import lac_pkg::*;
#(
  parameter int LA_W  = 8,
  parameter int PER_W = 20
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [1:0]        lead_mode_select,
  input  wire logic [LA_W-1:0]   angle_setting_input,
  input  wire logic              rotation_direction,
  input  wire logic              hall_u,
  input  wire logic              hall_v,
  input  wire logic              hall_w,
  input  wire logic              current_sign,
  output logic [7:0]             commut_phase,
  output logic [6:0]             lead_angle
);

  localparam int NPIN = LA_W + 7;

  logic [NPIN-1:0]   pin_raw;
  logic [NPIN-1:0]   pin_q;
  logic [LA_W-1:0]   la_code;
  logic [1:0]        mode_s;
  logic              dir_s;
  logic [2:0]        hall_s;
  logic              cur_s;
  logic [4:0]        step;
  logic [2:0]        sector_r;
  logic [2:0]        sector_nxt;
  logic              hall_ok;
  logic              sec_chg;
  logic [PER_W-1:0]  sec_cnt_r;
  logic [PER_W-1:0]  sec_per_r;
  logic [PER_W-1:0]  tick_cnt_r;
  logic [4:0]        frac_r;
  logic [7:0]        pos;
  logic [7:0]        lag;
  logic              hu_r;
  logic              per_ok_r;
  logic [PER_W-1:0]  per_cnt_r;
  logic [PER_W-1:0]  per_r;
  logic              meas_stb_r;
  logic [NBAND-1:1]  up_hit;
  logic [NBAND-1:1]  dn_hit;
  logic [4:0]        up_cnt;
  logic [4:0]        dn_cnt;
  logic [4:0]        band_r;
  logic              cur_q_r;
  logic [4:0]        fb_r;
  logic signed [6:0] ofs_fwd;
  logic signed [6:0] ofs;
  logic [2:0]        row;
  logic signed [6:0] lead_nxt;
  logic signed [6:0] lead_r;
  logic signed [6:0] adv;
  logic signed [9:0] psum;
  logic [7:0]        phase_r;
  logic              adv_en_r;
  logic              wr_go;
  logic              rd_go;
  logic              bvalid_r;
  logic              rvalid_r;
  logic [1:0]        bresp_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rd_word;
  logic              rd_hit;

  function automatic logic [4:0] lac_ones(input logic [NBAND-1:1] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 1; i < NBAND; i++) begin
      n = n + 5'(v[i]);
    end
    return n;
  endfunction : lac_ones

  assign pin_raw = {angle_setting_input, lead_mode_select,
                    rotation_direction, hall_u, hall_v, hall_w,
                    current_sign};

  // A level counts only once stages two and three agree
  for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
    logic [2:0] sh_r;
    logic       filt_r;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sh_r   <= 3'h0;
        filt_r <= 1'b0;
      end else begin
        sh_r <= {sh_r[1:0], pin_raw[gi]};
        if (sh_r[1] == sh_r[2]) begin
          filt_r <= sh_r[2];
        end
      end
    end
    assign pin_q[gi] = filt_r;
  end

  assign la_code = pin_q[NPIN-1 -: LA_W];
  assign mode_s  = pin_q[6:5];
  assign dir_s   = pin_q[4];
  assign hall_s  = pin_q[3:1];
  assign cur_s   = pin_q[0];

  assign step = la_code[LA_W-1 -: 5];

  // sectors numbered in forward U,V,W order
  always_comb begin
    hall_ok    = 1'b1;
    sector_nxt = sector_r;
    unique case (hall_s)
      3'h5:    sector_nxt = 3'h0;
      3'h4:    sector_nxt = 3'h1;
      3'h6:    sector_nxt = 3'h2;
      3'h2:    sector_nxt = 3'h3;
      3'h3:    sector_nxt = 3'h4;
      3'h1:    sector_nxt = 3'h5;
      default: hall_ok    = 1'b0;
    endcase
  end
  assign sec_chg = hall_ok && (sector_nxt != sector_r);

  // Interpolate 32 sub-steps per sector from the last sector time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sector_r   <= 3'h0;
      sec_cnt_r  <= '0;
      sec_per_r  <= '1;
      tick_cnt_r <= '0;
      frac_r     <= 5'h00;
    end else if (sec_chg) begin
      sector_r   <= sector_nxt;
      sec_per_r  <= sec_cnt_r;
      sec_cnt_r  <= '0;
      tick_cnt_r <= '0;
      frac_r     <= 5'h00;
    end else begin
      if (sec_cnt_r != '1) begin
        sec_cnt_r <= sec_cnt_r + 1'b1;
      end
      if (tick_cnt_r >= (sec_per_r >> SECT_SH)) begin
        tick_cnt_r <= '0;
        // Hold at sector end so a slowing rotor never overshoots
        if (frac_r != FRAC_MAX) begin
          frac_r <= frac_r + 5'h01;
        end
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // reverse rotation walks each sector downward
  assign pos = {sector_r, dir_s ? ~frac_r : frac_r};

  // Electrical period from hall U rising edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hu_r       <= 1'b0;
      per_ok_r   <= 1'b0;
      per_cnt_r  <= '0;
      per_r      <= '1;
      meas_stb_r <= 1'b0;
    end else begin
      hu_r       <= hall_s[2];
      meas_stb_r <= 1'b0;
      if (hall_s[2] && !hu_r) begin
        per_cnt_r  <= PER_W'(1);
        per_ok_r   <= 1'b1;
        // First rise only arms: the filter leaves reset low, no true period
        if (per_ok_r) begin
          per_r      <= per_cnt_r;
          meas_stb_r <= 1'b1;
        end
      end else if (per_cnt_r != '1) begin
        per_cnt_r <= per_cnt_r + 1'b1;
      end else if (per_r != '1) begin
        // Stalled rotor reads as lowest band
        per_r      <= '1;
        meas_stb_r <= 1'b1;
      end
    end
  end

  // one rise and one fall threshold per band above band 0
  for (genvar gk = 1; gk < NBAND; gk++) begin : g_band
    localparam int unsigned TUP = CLK_HZ / (BAND_HZ * gk);
    localparam int unsigned TDN = CLK_HZ / (BAND_HZ * gk - HYST_HZ);
    assign up_hit[gk] = per_r <= PER_W'(TUP);
    assign dn_hit[gk] = per_r <= PER_W'(TDN);
  end
  assign up_cnt = lac_ones(up_hit);
  assign dn_cnt = lac_ones(dn_hit);

  // rise on threshold, fall 50 Hz lower
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      band_r <= 5'h00;
    end else if (meas_stb_r) begin
      if (up_cnt > band_r) begin
        band_r <= up_cnt;
      end else if (dn_cnt < band_r) begin
        band_r <= dn_cnt;
      end
    end
  end

  assign lag = (dir_s && pos != 8'h00) ? 8'(TURN_UNITS - pos) : pos;

  // current edge position steers advance toward zero lag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_q_r <= 1'b0;
      fb_r    <= 5'h00;
    end else begin
      cur_q_r <= cur_s;
      if (cur_s && !cur_q_r && mode_s == MODE_PF) begin
        if (lag != 8'h00 && lag < HALF_TURN && fb_r != FB_MAX) begin
          fb_r <= fb_r + 5'h01;
        end else if (lag > HALF_TURN && fb_r != 5'h00) begin
          fb_r <= fb_r - 5'h01;
        end
      end
    end
  end

  assign ofs_fwd = (step < HALF_STEP) ? 7'(step)
                                      : -7'(step - HALF_STEP);
  assign ofs = dir_s ? -ofs_fwd : ofs_fwd;

  // Steps above 7 use the shallowest row 7
  assign row = (step > ROW_MAX) ? 3'h7 : step[2:0];

  // mode select; undefined level falls back to external
  always_comb begin
    unique case (mode_s)
      MODE_PF:   lead_nxt = 7'(fb_r) + ofs;
      MODE_FREQ: lead_nxt = 7'(FREQ_LUT[row][band_r]);
      // external angle, full scale saturates at step 31
      default:   lead_nxt = 7'(step);
    endcase
    if (!adv_en_r) begin
      lead_nxt = 7'sh00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lead_r <= 7'sh00;
    end else begin
      lead_r <= lead_nxt;
    end
  end

  // advance in direction of motion, wrapped to one turn
  assign adv  = dir_s ? -lead_r : lead_r;
  assign psum = $signed(10'(pos)) + 10'(adv);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= 8'h00;
    end else if (psum[9]) begin
      phase_r <= 8'(psum + TURN_S);
    end else if (psum >= TURN_S) begin
      phase_r <= 8'(psum - TURN_S);
    end else begin
      phase_r <= 8'(psum);
    end
  end

  assign commut_phase = phase_r;
  assign lead_angle   = lead_r;

  // Register slave: address and data taken together
  assign wr_go   = awvalid & wvalid & ~bvalid_r;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rd_go   = arvalid & ~rvalid_r;
  assign arready = rd_go;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_en_r <= CTRL_RST;
      bvalid_r <= 1'b0;
      bresp_r  <= AXI_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (awaddr == REG_CTRL) ? AXI_OKAY : AXI_SLVERR;
      if (awaddr == REG_CTRL && wstrb[0]) begin
        adv_en_r <= wdata[CTRL_EN];
      end
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr)
      REG_CTRL:   rd_word = 32'(adv_en_r);
      REG_STAT:   rd_word = 32'({sector_r, fb_r, band_r, step,
                                 dir_s, mode_s});
      REG_ANGLE:  rd_word = 32'({phase_r, 1'b0, lead_r});
      REG_PERIOD: rd_word = 32'(per_r);
      default:    rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= AXI_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      rdata_r  <= rd_word;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_lag_edge;
    cur_s && !cur_q_r && mode_s == MODE_PF;
  endsequence
  sequence s_lag_small;
    lag != 8'h00 && lag < HALF_TURN && fb_r != FB_MAX;
  endsequence
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence

  a_quant_full: assert property (
    (&la_code) |-> step == 5'h1F
  ) else $error("full scale input not at step 31");
  a_ext_lead: assert property (
    (mode_s == MODE_EXT && adv_en_r) |=> lead_r == 7'($past(step))
  ) else $error("external lead differs from setting step");
  a_ofs_low: assert property (
    (!dir_s && step == 5'h1F) |-> ofs == OFS_MIN
  ) else $error("forward step 31 offset not minimum");
  a_ofs_flip: assert property (
    ($stable(step) && $rose(dir_s)) |-> ofs == -$past(ofs)
  ) else $error("reverse did not negate offset");
  a_ofs_bound: assert property (
    ofs <= OFS_LIM && ofs >= -OFS_LIM
  ) else $error("offset beyond limit");
  a_band_rise: assert property (
    (meas_stb_r && up_cnt > band_r) |=> band_r == $past(up_cnt)
  ) else $error("band did not rise at threshold");
  a_band_hold: assert property (
    (meas_stb_r && up_cnt <= band_r && dn_cnt >= band_r)
      |=> $stable(band_r)
  ) else $error("band moved inside hysteresis");
  a_band_top: assert property (
    band_r <= TOP_BAND
  ) else $error("band above top");
  a_fb_advance: assert property (
    (s_lag_edge and s_lag_small) |=> fb_r == $past(fb_r) + 5'h01
  ) else $error("feedback did not advance on lagging current");
  a_phase_turn: assert property (
    commut_phase < TURN_UNITS
  ) else $error("phase outside one turn");
  a_wr_answer: assert property (
    s_wr_take |=> bvalid &&
      ((bresp == AXI_OKAY) == ($past(awaddr) == REG_CTRL))
  ) else $error("write not answered next cycle");

endmodule : lac_lead_angle
`default_nettype wire

// >>> verif/lac_motor_model.sv
// Motor model: hall sensor sequence and a current zero-cross line
`timescale 1ns/10ps
`default_nettype none
module lac_motor_model (
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic        dir,
  input  wire logic        cur_pulse,
  input  wire logic [15:0] sector_len,
  output logic             hall_u,
  output logic             hall_v,
  output logic             hall_w,
  output logic             current_sign
);
  logic [2:0]  idx_r = 3'h0;
  logic [15:0] cnt_r = 16'h0;
  logic [2:0]  cur_r = 3'h0;
  logic        wrap;

  assign wrap = run && (cnt_r >= sector_len - 16'h1);

  // Forward walks U,V,W order; reverse walks the table backwards
  always_comb begin
    case (idx_r)
      3'h0:    {hall_u, hall_v, hall_w} = 3'h5;
      3'h1:    {hall_u, hall_v, hall_w} = 3'h4;
      3'h2:    {hall_u, hall_v, hall_w} = 3'h6;
      3'h3:    {hall_u, hall_v, hall_w} = 3'h2;
      3'h4:    {hall_u, hall_v, hall_w} = 3'h3;
      default: {hall_u, hall_v, hall_w} = 3'h1;
    endcase
  end

  // Length read every cycle so a speed change stretches the live sector
  always_ff @(posedge aclk) begin
    cnt_r <= (!run || wrap) ? 16'h0 : cnt_r + 16'h1;
    if (wrap && dir)
      idx_r <= (idx_r == 3'h0) ? 3'h5 : idx_r - 3'h1;
    else if (wrap)
      idx_r <= (idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1;
  end

  // Held four cycles so the pin filter accepts the edge
  always_ff @(posedge aclk) begin
    if (cur_pulse)
      cur_r <= 3'h4;
    else if (cur_r != 3'h0)
      cur_r <= cur_r - 3'h1;
  end
  assign current_sign = (cur_r != 3'h0);
endmodule : lac_motor_model
`default_nettype wire

// >>> verif/lead_angle_controller_tb_top.sv
// Self-checking bench for the lead angle controller
`timescale 1ns/10ps
`default_nettype none
module lead_angle_controller_tb_top
  import lac_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cur_pulse, run;
  logic        rotation_direction, hall_u, hall_v, hall_w, current_sign;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r, lead_mode_select;
  logic [7:0]  angle_setting_input, commut_phase;
  logic [6:0]  lead_angle;
  logic [15:0] sec_len;
  int          fail_count, checks_done, p0, ph;

  lac_lead_angle #(.LA_W(8), .PER_W(20)) u_dut (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .lead_mode_select, .angle_setting_input, .rotation_direction, .hall_u,
    .hall_v, .hall_w, .current_sign, .commut_phase, .lead_angle);

  lac_motor_model u_mot (.aclk, .run, .dir(rotation_direction), .cur_pulse,
    .sector_len(sec_len), .hall_u, .hall_v, .hall_w, .current_sign);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // Response code starts illegal; a lost answer never leaves the bvalid wait and ends at the watchdog
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic go;
    go = 1'b1;
    r = 2'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (go) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        go = 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [3:0] a);
    logic go;
    go = 1'b1;
    r = 2'h1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (go) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        go = 1'b0;
      end
    end
  endtask : rd

  // Low three bits are below one step, so they are drawn at random
  task automatic pins(input logic [1:0] m, input logic [4:0] s,
                      input logic dv);
    @(posedge aclk);
    lead_mode_select <= m;
    angle_setting_input <= {s, 3'($urandom)};
    rotation_direction <= dv;
    repeat (12) @(posedge aclk);
  endtask : pins

  task automatic turn(input logic [15:0] len, input int n);
    @(posedge aclk);
    sec_len <= len;
    repeat (n) @(posedge hall_u);
    repeat (20) @(posedge aclk);
  endtask : turn

  function automatic logic [6:0] ofs(input logic [4:0] s, input logic dv);
    logic [6:0] m;
    m = {3'h0, s[3:0]};
    return (s[4] ^ dv) ? 7'h00 - m : m;
  endfunction : ofs

  initial begin
    #2_400_000;
    fail_count++;
    summarize();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cur_pulse, run} = '0;
    {awaddr, araddr, wstrb, wdata} = '0;
    {lead_mode_select, angle_setting_input, rotation_direction} = '0;
    sec_len = 16'h012C;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(32'h244545E3));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(REG_CTRL);
    check({d[29:0], r}, {30'h1, AXI_OKAY});
    rd(4'h2);
    check({d[29:0], r}, {30'h0, AXI_SLVERR});
    wr(REG_ANGLE, 32'h0);
    check(r, AXI_SLVERR);
    $display("Register access test done");
    for (int m = 0; m < 128; m++) begin
      pins(m[6] ? 2'h3 : MODE_EXT, 5'(m), m[5]);
      if (m[4:0] == 0) p0 = int'(commut_phase);
      ph = m[5] ? (p0 + 192 - m[4:0]) % 192 : (p0 + m[4:0]) % 192;
      check(lead_angle, 7'(m[4:0]));
      check(commut_phase, 8'(ph));
      if (m == 63) begin
        rd(REG_STAT);
        check(d[7:2], {5'h1F, 1'b1});
      end
    end
    $display("External lead test done");
    pins(MODE_EXT, 5'h14, 1'b0);
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge aclk);
    check(lead_angle, 7'h00);
    wr(REG_CTRL, 32'h1);
    rd(REG_ANGLE);
    check(d[7:0], 8'h14);
    $display("Advance enable test done");
    for (int m = 0; m < 64; m++) begin
      pins(MODE_PF, 5'(m), m[5]);
      check(lead_angle, ofs(5'(m), m[5]));
    end
    $display("Hall offset test done");
    pins(MODE_PF, 5'h10, 1'b0);
    run <= 1'b1;
    for (int n = 0; n < 4000 && {hall_u, hall_v, hall_w} !== 3'h4; n++)
      @(posedge aclk);
    run <= 1'b0;
    repeat (400) @(posedge aclk);
    repeat (3) begin
      cur_pulse <= 1'b1;
      @(posedge aclk);
      cur_pulse <= 1'b0;
      repeat (15) @(posedge aclk);
    end
    check(lead_angle, 7'h03);
    $display("Phase feedback test done");
    pins(MODE_FREQ, 5'h04, 1'b0);
    run <= 1'b1;
    turn(16'h0096, 25);
    check(lead_angle, 7'h19);
    rd(REG_STAT);
    check(d[12:8], 5'h14);
    pins(MODE_FREQ, 5'h09, 1'b0);
    check(lead_angle, 7'h05);
    pins(MODE_FREQ, 5'h04, 1'b0);
    turn(16'h0D48, 2);
    check(lead_angle, 7'h19);
    turn(16'h0DAC, 1);
    check(lead_angle, 7'h17);
    $display("Frequency lead test done");
    summarize();
  end
endmodule : lead_angle_controller_tb_top
`default_nettype wire
